// ### pkg/tone_pkg.sv
// package: register map, field layout, tone table and timing for the dual tone generator
// What this block does
// - sixteen row/column pairs and eight single tones come out of one output
// - tones are timed from the system clock; software runs it at full speed
// - power-down parks the phase accumulators and zeroes the output (tuning steps still follow the code); both registers stay readable and writable
// - control bit 0 set means powered down, clear means operating
// - control bit 2 set lets the tone reach the output, clear holds bias
// - code bits 3..0 pick the column tone, bits 7..4 the row tone
// - a new code while running switches the tone pair at once
// - output zero in power-down, mid-scale bias when disabled or code zero
// - powered, enabled, valid code: tone sum rides on the mid-scale bias
// - one-hot nibbles: rows 697/770/852/941 Hz, columns 1209/1336/1477/1633 Hz
// - realised frequencies stay close to nominal, crystal error aside
`default_nettype none
package tone_pkg;
  // ==========================================================
  // clocking and phase arithmetic
  localparam int CLK_HZ = 20000000;
  localparam int PHASE_W = 24;
  localparam int LUT_AW = 5;
  localparam int LUT_DW = 8;
  typedef logic [PHASE_W-1:0] phase_t;
  typedef logic signed [LUT_DW-1:0] sample_t;

  // ==========================================================
  // register map
  localparam logic [7:0] TONE_CONTROL_ADDR = 8'h20;
  localparam logic [7:0] TONE_CODE_SELECT_ADDR = 8'h21;
  localparam logic [7:0] TONE_CONTROL_RESET = 8'h01;
  localparam logic [7:0] TONE_CODE_RESET = 8'h00;
  localparam logic [7:0] TONE_CONTROL_KEEP = 8'h5d; // bits 0,2,3,4,6 are stored
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ==========================================================
  // output converter codes
  localparam logic [7:0] DAC_ZERO = 8'h00;
  localparam logic [7:0] DAC_BIAS = 8'h80;
  localparam logic [7:0] DAC_MIN = 8'h08;
  localparam logic [7:0] DAC_MAX = 8'hf8;

  // ==========================================================
  // nominal tone frequencies in Hz, index = one-hot bit position
  localparam int ROW_HZ [4] = '{697, 770, 852, 941};
  localparam int COL_HZ [4] = '{1209, 1336, 1477, 1633};

  // ==========================================================
  // field layouts, msb first
  typedef struct packed {
    logic unused7;
    logic keep6;
    logic unused5;
    logic keep4;
    logic keep3;
    logic tone_enable;
    logic unused1;
    logic generator_power_down;
  } tone_control_s;

  typedef struct packed {
    logic [3:0] row_frequency_select;
    logic [3:0] column_frequency_select;
  } tone_code_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef enum logic [2:0] {
    GEN_OFF = 3'b001,
    GEN_BIAS = 3'b010,
    GEN_TONE = 3'b100
  } gen_state_e;

  // ==========================================================
  // one full sine period, 32 points, peak 60
  localparam sample_t SINE_LUT [32] = '{
    8'h00, 8'h0c, 8'h17, 8'h21, 8'h2a, 8'h32, 8'h37, 8'h3b,
    8'h3c, 8'h3b, 8'h37, 8'h32, 8'h2a, 8'h21, 8'h17, 8'h0c,
    8'h00, 8'hf4, 8'he9, 8'hdf, 8'hd6, 8'hce, 8'hc9, 8'hc5,
    8'hc4, 8'hc5, 8'hc9, 8'hce, 8'hd6, 8'hdf, 8'he9, 8'hf4};

  // rounded tuning word for a frequency at the system clock rate
  function automatic phase_t tone_step(input int hz);
    longint unsigned w;
    w = (longint'(hz) * (64'd1 << PHASE_W) + longint'(CLK_HZ / 2)) / longint'(CLK_HZ);
    return phase_t'(w);
  endfunction
endpackage
`default_nettype wire

// ### rtl/sine_rom.sv
// sine sample table with two registered read ports
`default_nettype none
module sine_rom
  import tone_pkg::*;
#(
  parameter int AW = LUT_AW,
  parameter int DW = LUT_DW
) (
  input wire logic sys_clk_in, // system clock
  input wire logic resetn_in, // async reset, active low
  input wire logic [AW-1:0] addr_a_in, // row tone phase index
  input wire logic [AW-1:0] addr_b_in, // column tone phase index
  output logic signed [DW-1:0] data_a_out, // row sample, one cycle later
  output logic signed [DW-1:0] data_b_out // column sample, one cycle later
);
  // registered reads keep the table out of the output timing path
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      data_a_out <= '0;
      data_b_out <= '0;
    end else begin
      data_a_out <= SINE_LUT[addr_a_in];
      data_b_out <= SINE_LUT[addr_b_in];
    end
  end
endmodule
`default_nettype wire

// ### rtl/dual_tone_generator.sv
// dual tone generator: register port, phase accumulators and output mixer
//
// Implementation choice: the address-and-strobe port.
`default_nettype none
module dual_tone_generator
  import tone_pkg::*;
(
  input wire logic sys_clk_in, // 20 MHz system clock
  input wire logic resetn_in, // async reset, active low
  input wire logic [7:0] reg_addr_in, // register address
  input wire logic [7:0] reg_wdata_in, // register write data
  input wire logic reg_wr_in, // write strobe, one cycle
  input wire logic reg_rd_in, // read strobe, one cycle
  output logic [7:0] reg_rdata_out, // read data, cycle after strobe
  output logic [7:0] tone_dac_out, // converter code for the tone pin
  output logic tone_active_out // high while a tone is being synthesised
);

  // ==========================================================
  // helpers

  // a nibble is legal when it is zero or has exactly one bit set
  function automatic logic nibble_ok(input logic [3:0] n);
    return (n & (n - 4'h1)) == 4'h0;
  endfunction

  // one-hot nibble to tuning word; zero or illegal nibble gives no step
  function automatic phase_t group_step(input logic [3:0] sel, input logic is_row);
    phase_t s;
    s = '0;
    for (int i = 0; i < 4; i++) begin
      if (sel == 4'(1 << i)) begin
        s = is_row ? tone_step(ROW_HZ[i]) : tone_step(COL_HZ[i]);
      end
    end
    return s;
  endfunction

  // ==========================================================
  // register port

  reg_req_s req;
  tone_control_s tone_control;
  tone_code_s tone_code_select;

  // bundle the bus pins so the decode below reads as one request
  assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

  // control register; unstored bits never hold a one
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tone_control <= tone_control_s'(TONE_CONTROL_RESET);
    end else if (req.wr && req.addr == TONE_CONTROL_ADDR) begin
      // writes are honoured in power-down too
      tone_control <= tone_control_s'(req.wdata & TONE_CONTROL_KEEP);
    end
  end

  // tone code register, accepted in every state
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tone_code_select <= tone_code_s'(TONE_CODE_RESET);
    end else if (req.wr && req.addr == TONE_CODE_SELECT_ADDR) begin
      tone_code_select <= tone_code_s'(req.wdata);
    end
  end

  // read data live only in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= UNMAPPED_READ;
    end else if (req.rd) begin
      case (req.addr)
        TONE_CONTROL_ADDR: reg_rdata_out <= 8'(tone_control) & TONE_CONTROL_KEEP;
        TONE_CODE_SELECT_ADDR: reg_rdata_out <= 8'(tone_code_select);
        default: reg_rdata_out <= UNMAPPED_READ;
      endcase
    end else begin
      reg_rdata_out <= UNMAPPED_READ;
    end
  end

  // ==========================================================
  // code decode

  logic row_ok;
  logic col_ok;
  logic code_valid;

  // any illegal nibble is treated as no tone, rather than an odd mixture
  assign row_ok = nibble_ok(tone_code_select.row_frequency_select);
  assign col_ok = nibble_ok(tone_code_select.column_frequency_select);
  assign code_valid = row_ok && col_ok && (8'(tone_code_select) != 8'h00);

  // ==========================================================
  // generator state

  gen_state_e state;
  gen_state_e next_state;
  gen_state_e state_q1;

  // power-down wins over everything, then enable and a usable code
  always_comb begin
    next_state = GEN_BIAS;
    if (tone_control.generator_power_down) begin
      next_state = GEN_OFF;
    end else if (tone_control.tone_enable && code_valid) begin
      next_state = GEN_TONE;
    end
  end

  // no duration timer: the tone runs until software drops the enable
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= GEN_OFF;
    end else begin
      state <= next_state;
    end
  end

  // state delayed to line up with the registered table samples
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q1 <= GEN_OFF;
    end else begin
      state_q1 <= state;
    end
  end

  assign tone_active_out = (state == GEN_TONE);

  // ==========================================================
  // phase accumulators

  phase_t row_step;
  phase_t col_step;
  phase_t row_phase;
  phase_t col_phase;

  // steps follow the code register directly, so a new code lands at once
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      row_step <= '0;
      col_step <= '0;
    end else begin
      row_step <= group_step(tone_code_select.row_frequency_select, 1'b1);
      col_step <= group_step(tone_code_select.column_frequency_select, 1'b0);
    end
  end

  // phases park at zero outside a tone so every burst starts at a zero crossing
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      row_phase <= '0;
      col_phase <= '0;
    end else if (state != GEN_TONE) begin
      row_phase <= '0;
      col_phase <= '0;
    end else begin
      // a zero step parks its phase, else a stale index would add a dc offset
      row_phase <= (row_step == '0) ? '0 : phase_t'(row_phase + row_step);
      col_phase <= (col_step == '0) ? '0 : phase_t'(col_phase + col_step);
    end
  end

  // ==========================================================
  // sine lookup

  sample_t row_sample;
  sample_t col_sample;

  sine_rom #(
    .AW(LUT_AW),
    .DW(LUT_DW)
  ) u_sine_rom (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .addr_a_in(row_phase[PHASE_W-1 -: LUT_AW]),
    .addr_b_in(col_phase[PHASE_W-1 -: LUT_AW]),
    .data_a_out(row_sample),
    .data_b_out(col_sample)
  );

  // ==========================================================
  // output mixer

  logic signed [9:0] mix;

  // peak 60 per tone keeps the sum well inside the 8-bit range
  assign mix = $signed({2'b00, DAC_BIAS}) + 10'(row_sample) + 10'(col_sample);

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tone_dac_out <= DAC_ZERO;
    end else begin
      case (state_q1)
        GEN_OFF: tone_dac_out <= DAC_ZERO;
        GEN_BIAS: tone_dac_out <= DAC_BIAS;
        GEN_TONE: tone_dac_out <= mix[7:0];
        default: tone_dac_out <= DAC_ZERO;
      endcase
    end
  end

  // ==========================================================
  // checks

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  // pipeline from control bit to pin is three edges deep
  power_down_zero_a: assert property (
    tone_control.generator_power_down [*4] |-> tone_dac_out == DAC_ZERO)
    else $error("output not zero in power-down");

  disabled_bias_a: assert property (
    (!tone_control.generator_power_down && !tone_control.tone_enable) [*4]
      |-> tone_dac_out == DAC_BIAS)
    else $error("output not at bias while disabled");

  zero_code_bias_a: assert property (
    (!tone_control.generator_power_down && 8'(tone_code_select) == 8'h00) [*4]
      |-> tone_dac_out == DAC_BIAS)
    else $error("output not at bias with empty code");

  tone_in_range_a: assert property (
    state_q1 == GEN_TONE |=> tone_dac_out >= DAC_MIN && tone_dac_out <= DAC_MAX)
    else $error("tone sample outside mixer range");

  unused_bits_zero_a: assert property (
    req.rd && req.addr == TONE_CONTROL_ADDR
      |=> reg_rdata_out[7] == 1'b0 && reg_rdata_out[5] == 1'b0 && reg_rdata_out[1] == 1'b0)
    else $error("unused control bit read as one");

  control_readback_a: assert property (
    req.wr && req.addr == TONE_CONTROL_ADDR ##1 req.rd && req.addr == TONE_CONTROL_ADDR
      |=> reg_rdata_out == ($past(req.wdata, 2) & TONE_CONTROL_KEEP))
    else $error("control readback differs from write");

  code_write_pd_a: assert property (
    tone_control.generator_power_down && req.wr && req.addr == TONE_CODE_SELECT_ADDR
      |=> 8'(tone_code_select) == $past(req.wdata))
    else $error("code write lost in power-down");

  new_code_step_a: assert property (
    state == GEN_TONE && req.wr && req.addr == TONE_CODE_SELECT_ADDR
      |-> ##2 row_step == group_step($past(req.wdata[7:4], 2), 1'b1))
    else $error("row step did not follow new code");

  single_tone_a: assert property (
    state == GEN_TONE && tone_code_select.column_frequency_select == 4'h0
      && $past(state) == GEN_TONE && $past(col_step) == '0 |-> col_phase == '0)
    else $error("column phase moved in single tone");

  phase_advance_a: assert property (
    state == GEN_TONE && $past(state) == GEN_TONE
      |-> row_phase == (($past(row_step) == '0) ? '0
        : phase_t'($past(row_phase) + $past(row_step))))
    else $error("row phase did not advance by step");

  rd_one_cycle_a: assert property (
    !req.rd |=> reg_rdata_out == UNMAPPED_READ)
    else $error("read data held past its cycle");

  // ==========================================================
  // state, register and tuning checks

  power_down_off_a: assert property (
    tone_control.generator_power_down |=> state == GEN_OFF && !tone_active_out)
    else $error("generator ran in power-down");

  valid_code_tone_a: assert property (
    !tone_control.generator_power_down && tone_control.tone_enable
      && $onehot0(tone_code_select.row_frequency_select)
      && $onehot0(tone_code_select.column_frequency_select)
      && 8'(tone_code_select) != 8'h00 |=> state == GEN_TONE)
    else $error("valid enabled code gave no tone");

  tone_start_bias_a: assert property (
    state_q1 == GEN_TONE && $past(state_q1) != GEN_TONE |=> tone_dac_out == DAC_BIAS)
    else $error("tone did not start from the bias level");

  phase_parked_a: assert property (
    state != GEN_TONE |=> row_phase == '0 && col_phase == '0)
    else $error("phase accumulator ran outside a tone");

  row_697_step_a: assert property (
    tone_code_select.row_frequency_select == 4'h1 |=> row_step == tone_step(ROW_HZ[0]))
    else $error("row step wrong for first row tone");

  row_770_step_a: assert property (
    tone_code_select.row_frequency_select == 4'h2 |=> row_step == tone_step(ROW_HZ[1]))
    else $error("row step wrong for second row tone");

  row_852_step_a: assert property (
    tone_code_select.row_frequency_select == 4'h4 |=> row_step == tone_step(ROW_HZ[2]))
    else $error("row step wrong for third row tone");

  row_941_step_a: assert property (
    tone_code_select.row_frequency_select == 4'h8 |=> row_step == tone_step(ROW_HZ[3]))
    else $error("row step wrong for fourth row tone");

  col_1209_step_a: assert property (
    tone_code_select.column_frequency_select == 4'h1 |=> col_step == tone_step(COL_HZ[0]))
    else $error("column step wrong for first column tone");

  col_1336_step_a: assert property (
    tone_code_select.column_frequency_select == 4'h2 |=> col_step == tone_step(COL_HZ[1]))
    else $error("column step wrong for second column tone");

  col_1477_step_a: assert property (
    tone_code_select.column_frequency_select == 4'h4 |=> col_step == tone_step(COL_HZ[2]))
    else $error("column step wrong for third column tone");

  col_1633_step_a: assert property (
    tone_code_select.column_frequency_select == 4'h8 |=> col_step == tone_step(COL_HZ[3]))
    else $error("column step wrong for fourth column tone");

  row_zero_step_a: assert property (
    tone_code_select.row_frequency_select == 4'h0 |=> row_step == '0)
    else $error("empty row nibble left a row step");

  col_zero_step_a: assert property (
    tone_code_select.column_frequency_select == 4'h0 |=> col_step == '0)
    else $error("empty column nibble left a column step");

  single_col_tone_a: assert property (
    state == GEN_TONE && tone_code_select.row_frequency_select == 4'h0
      && $past(state) == GEN_TONE && $past(row_step) == '0 |-> row_phase == '0)
    else $error("row phase moved in single tone");

  col_phase_step_a: assert property (
    state == GEN_TONE && $past(state) == GEN_TONE && $past(col_step) != '0
      |-> col_phase == phase_t'($past(col_phase) + $past(col_step)))
    else $error("column phase did not advance by step");

  code_readback_a: assert property (
    req.rd && req.addr == TONE_CODE_SELECT_ADDR |=> reg_rdata_out == $past(8'(tone_code_select)))
    else $error("code readback differs from register");

  control_write_a: assert property (
    req.wr && req.addr == TONE_CONTROL_ADDR |=> 8'(tone_control) == ($past(req.wdata) & TONE_CONTROL_KEEP))
    else $error("control write not stored");

  switch_keeps_tone_a: assert property (
    state == GEN_TONE && tone_control.tone_enable && !tone_control.generator_power_down
      && req.wr && req.addr == TONE_CODE_SELECT_ADDR
      && $onehot(req.wdata[7:4]) && $onehot(req.wdata[3:0]) |=> ##1 state == GEN_TONE)
    else $error("tone dropped on a code change");

endmodule
`default_nettype wire

// ### bench/tone_line_monitor.sv
// tone line monitor: times the tone seen at the converter pin
`default_nettype none
module tone_line_monitor
  import tone_pkg::*;
(
  input wire logic sys_clk_in, // system clock
  input wire logic resetn_in, // async reset, active low
  input wire logic [7:0] tone_dac_in, // converter code from the generator
  output logic [31:0] period_out, // cycles between the last two upward crossings
  output logic [31:0] cross_count_out // upward bias crossings seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] prev_code;
  logic [31:0] cycle_count;
  // ==========================================================
  // upward crossing of the bias code marks one period
  // only single tones give a clean period; dual tones cross irregularly
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prev_code <= 8'h00;
      cycle_count <= 32'h0;
      period_out <= 32'h0;
      cross_count_out <= 32'h0;
    end else begin
      prev_code <= tone_dac_in;
      if (prev_code <= DAC_BIAS && tone_dac_in > DAC_BIAS) begin
        period_out <= cycle_count + 32'h1;
        cycle_count <= 32'h0;
        cross_count_out <= cross_count_out + 32'h1;
      end else begin
        cycle_count <= cycle_count + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/tb_dual_tone_generator.sv
// testbench for the dual tone generator: registers, pin states and tone timing
`default_nettype none
module tb_dual_tone_generator
  import tone_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in, resetn_in, reg_wr_in, reg_rd_in, tone_active_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, tone_dac_out;
  logic [31:0] period, crosses;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  // ==========================================================
  // design and far-side monitor
  dual_tone_generator u_dual_tone_generator (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .tone_dac_out(tone_dac_out),
    .tone_active_out(tone_active_out));
  tone_line_monitor u_tone_line_monitor (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .tone_dac_in(tone_dac_out), .period_out(period), .cross_count_out(crosses));
  // 50 ns period
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  // hang guard, well above the longest tone measurement
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      report_and_stop();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic set_tone(input logic [7:0] ctrl, input logic [7:0] code);
    reg_write(TONE_CODE_SELECT_ADDR, code);
    reg_write(TONE_CONTROL_ADDR, ctrl);
    settle(4);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset_values();
    logic [7:0] d;
    reg_read(TONE_CONTROL_ADDR, d);
    check(d, TONE_CONTROL_RESET);
    reg_read(TONE_CODE_SELECT_ADDR, d);
    check(d, TONE_CODE_RESET);
    check(tone_dac_out, DAC_ZERO);
  endtask
  task automatic t_access();
    logic [7:0] d;
    reg_read(8'h22, d);
    check(d, UNMAPPED_READ);
    // write then read back to back; reserved bits keep their reset value
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= TONE_CONTROL_ADDR;
    reg_wdata_in <= 8'ha7;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
    check(d, 8'h05);
    reg_write(TONE_CONTROL_ADDR, 8'h01);
  endtask
  task automatic t_power_down();
    logic [7:0] d;
    set_tone(8'h05, 8'h11);
    reg_read(TONE_CODE_SELECT_ADDR, d);
    check(d, 8'h11);
    reg_read(TONE_CONTROL_ADDR, d);
    check(d, 8'h05);
    repeat (20) begin
      settle(1);
      check(tone_dac_out, DAC_ZERO);
      check(tone_active_out, 1'b0);
    end
  endtask
  task automatic t_bias();
    logic [7:0] idle [4] = '{8'h00, 8'h22, 8'h48, 8'h84};
    set_tone(8'h00, 8'h11);
    check(tone_dac_out, DAC_BIAS);
    // empty code while enabled, then legal codes while disabled
    for (int i = 0; i < 4; i++) begin
      set_tone((i == 0) ? 8'h04 : 8'h00, idle[i]);
      check(tone_dac_out, DAC_BIAS);
      check(tone_active_out, 1'b0);
    end
  endtask
  task automatic t_dual_present();
    logic moved;
    logic in_range;
    moved = 1'b0;
    in_range = 1'b1;
    set_tone(8'h04, 8'h11);
    check(tone_active_out, 1'b1);
    repeat (1200) begin
      settle(1);
      if (tone_dac_out !== DAC_BIAS) moved = 1'b1;
      if ((tone_dac_out >= DAC_MIN && tone_dac_out <= DAC_MAX) !== 1'b1) in_range = 1'b0;
    end
    check(moved, 1'b1);
    check(in_range, 1'b1);
    // software ends the tone by dropping the enable
    reg_write(TONE_CONTROL_ADDR, 8'h00);
    settle(4);
    check(tone_dac_out, DAC_BIAS);
  endtask
  task automatic t_all_codes();
    logic [7:0] code;
    for (int r = 0; r < 5; r++) begin
      for (int c = 0; c < 5; c++) begin
        code = {(r < 4) ? 4'(1 << r) : 4'h0, (c < 4) ? 4'(1 << c) : 4'h0};
        if (code != 8'h00) begin
          set_tone(8'h04, code);
          check(tone_active_out, 1'b1);
        end
      end
    end
  endtask
  // a new code while running must not drop the tone even for a cycle
  task automatic t_switch();
    set_tone(8'h04, 8'h11);
    fork
      reg_write(TONE_CODE_SELECT_ADDR, 8'h88);
      repeat (8) begin
        settle(1);
        check(tone_active_out, 1'b1);
      end
    join
  endtask
  task automatic t_freq(input logic [7:0] code, input int hz);
    logic [31:0] c0;
    int exp_p;
    int diff;
    exp_p = CLK_HZ / hz;
    set_tone(8'h00, code);
    reg_write(TONE_CONTROL_ADDR, 8'h04);
    c0 = crosses;
    for (int i = 0; i < 2 * exp_p + 100 && crosses < c0 + 2; i++) settle(1);
    #1 diff = int'(period) - exp_p;
    check(crosses >= c0 + 2, 1'b1);
    check(diff * 100 <= exp_p && diff * 100 >= -exp_p, 1'b1);
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic do_reset();
    resetn_in <= 1'b0;
    repeat (20) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    @(posedge sys_clk_in);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    resetn_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    do_reset();
    t_reset_values();
    t_access();
    t_power_down();
    t_bias();
    t_dual_present();
    t_all_codes();
    t_switch();
    t_freq(8'h80, ROW_HZ[3]);
    t_freq(8'h08, COL_HZ[3]);
    do_reset();
    t_reset_values();
    report_and_stop();
  end
endmodule
`default_nettype wire
